// ==== common/oag_pkg.sv ====
// operand addressing package: codes, field layouts and carrier structs
// assumes a single core clock domain; all users import oag_pkg::*
//
// Contract
// - immediate mode returns the operand taken straight from the instruction byte.
// - direct mode uses the operand field as address, only in sfr, internal ram or bit space.
// - sfr and bit space are reached only by direct addressing, never by indirect access.
// - indirect mode reads r0 or r1 and uses its contents as internal ram address.
// - register mode picks r0 to r7 from the lowest three opcode bits.
// - accumulator, b, data pointer and carry are selected implicitly by the opcode.
// - working registers are mapped into the bank chosen by the two bank-select bits.
// - relative branch target is the program counter plus the second instruction byte.
// - the relative offset is a signed byte, giving a reach of -128 to +127.
// - branch_if_carry keeps the program counter when carry is clear, else loads the target.
// - indexed mode uses the program counter or the data pointer as base.
// - code_table_move adds accumulator to data pointer or program counter, fetches that byte into accumulator.
// - bit operations use carry as bit accumulator and take the bit address from the operand.
// - bit and byte addresses share one encoding; the opcode decides which is meant.
package oag_pkg;

    // ****************************************************************
    // opcodes and opcode fields
    // ****************************************************************
    localparam logic [7:0] OP_BR_CARRY   = 8'h40; // branch_if_carry
    localparam logic [7:0] OP_BR_NCARRY  = 8'h50;
    localparam logic [7:0] OP_BR_ZERO    = 8'h60;
    localparam logic [7:0] OP_BR_NZERO   = 8'h70;
    localparam logic [7:0] OP_BR_ALWAYS  = 8'h80;
    localparam logic [7:0] OP_CTM_PC     = 8'h83; // code_table_move, pc base
    localparam logic [7:0] OP_CTM_DP     = 8'h93; // code_table_move, data_pointer base
    localparam logic [7:0] OP_INC_DP     = 8'ha3;
    localparam logic [7:0] OP_DIV_AB     = 8'h84;
    localparam logic [7:0] OP_MUL_AB     = 8'ha4;
    localparam logic [3:0] LO_DIRECT     = 4'h5;
    localparam logic [3:0] LO_IMM_ACC    = 4'h4;
    localparam logic [3:0] LO_BIT        = 4'h2;
    localparam logic [3:0] LO_CARRY      = 4'h3;
    localparam logic [3:0] HI_IMM_FIRST  = 4'h2;
    localparam logic [3:0] HI_IMM_LAST   = 4'h7;
    localparam logic [3:0] HI_BIT_FIRST  = 4'h7;
    localparam logic [3:0] HI_BIT_LAST   = 4'hd;
    localparam logic [3:0] HI_CARRY_FIRST = 4'hb;
    localparam logic [3:0] HI_CARRY_LAST = 4'hd;
    localparam int         REG_BIT       = 3;     // opcode bit marking register mode
    localparam logic [2:0] IND_PATTERN   = 3'b011; // opcode [3:1] of @r0/@r1

    // ****************************************************************
    // address space layout
    // ****************************************************************
    localparam logic [7:0] SFR_BASE      = 8'h80;
    localparam logic [7:0] BIT_RAM_BASE  = 8'h20;
    localparam logic [7:0] SFR_ROW_MASK  = 8'hf8;
    localparam int         BANK_SHIFT    = 3;     // eight registers per bank

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_IMM = 3'h0, MODE_DIR = 3'h1, MODE_IND = 3'h2, MODE_REG = 3'h3,
        MODE_REL = 3'h4, MODE_IDX = 3'h5, MODE_BIT = 3'h6, MODE_IMP = 3'h7
    } oag_mode_t;

    typedef enum logic [2:0] {
        SP_NONE = 3'h0, SP_IMM = 3'h1, SP_IRAM = 3'h2, SP_SFR = 3'h3,
        SP_BIT  = 3'h4, SP_CODE = 3'h5, SP_CORE = 3'h6
    } oag_space_t;

    typedef enum logic [2:0] {
        IMP_NONE = 3'h0, IMP_ACC = 3'h1, IMP_B = 3'h2, IMP_DATA_POINTER = 3'h3, IMP_CARRY = 3'h4
    } oag_imp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_PTR = 3'b010, ST_CODE = 3'b100
    } oag_state_t;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [7:0] op;     // opcode byte
        logic [7:0] b1;     // second instruction byte
    } oag_instr_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [15:0] data_pointer;
        logic [15:0] pc_next;   // address of the following instruction
        logic        carry;
        logic        bank_select_high;
        logic        bank_select_low;
    } oag_core_t;

    typedef struct packed {
        logic        rd;
        oag_space_t  space;
        logic [15:0] addr;
    } oag_mem_req_t;

    typedef struct packed {
        oag_mode_t   mode;
        oag_space_t  space;
        logic [15:0] addr;
        logic [7:0]  value;
        logic [2:0]  bit_idx;
        oag_imp_t    imp;
        logic        pc_load;
        logic [15:0] pc_target;
        logic        acc_load;
        logic [7:0]  acc_data;
    } oag_res_t;

    typedef struct packed {
        oag_state_t   st;
        oag_mem_req_t mem;
        oag_res_t     res;
        logic         done;
    } oag_regs_t;

endpackage

// ==== rtl/oag_bank_map.sv ====
// working register to internal ram address mapping
// assumes bank bits and register index come from the core on the same clock
`timescale 1ns/1ps

module oag_bank_map
    import oag_pkg::*;
(
    // bank selection
    input  wire logic       i_bank_hi,
    input  wire logic       i_bank_lo,
    // register index
    input  wire logic [2:0] i_reg_idx,
    // ram address of the register
    output logic [7:0]      o_ram_addr
);

    // bank number times eight plus register index
    assign o_ram_addr = 8'({i_bank_hi, i_bank_lo, i_reg_idx});

endmodule

// ==== rtl/oag_operand_addr_gen.sv ====
// operand address generator: decodes the addressing mode of one instruction
// assumes the core holds the request until o_ready and answers reads with i_mem_ack
// one instruction in flight; a request while busy is dropped
// a memory answer may take any number of cycles
`timescale 1ns/1ps

module oag_operand_addr_gen
    import oag_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // instruction request
    input  wire logic         i_valid,
    input  wire oag_instr_t   i_instr,
    input  wire oag_core_t    i_core,
    output logic              o_ready,
    // memory read port
    output oag_mem_req_t      o_mem,
    input  wire logic         i_mem_ack,
    input  wire logic [7:0]   i_mem_rdata,
    // result
    output logic              o_done,
    output oag_res_t          o_res
);

    // ****************************************************************
    // decode functions
    // ****************************************************************

    // direct byte address: upper half is sfr space, lower half internal ram
    function automatic oag_space_t direct_space(input logic [7:0] a);
        if (a >= SFR_BASE) begin
            direct_space = SP_SFR;
        end else begin
            direct_space = SP_IRAM;
        end
    endfunction

    // bit address to the byte that holds it, same encoding as direct bytes
    function automatic logic [7:0] bit_byte(input logic [7:0] ba);
        if (ba >= SFR_BASE) begin
            // sfr bit: row of eight
            bit_byte = ba & SFR_ROW_MASK;
        end else begin
            // ram bit: bit area byte
            bit_byte = 8'(BIT_RAM_BASE + {4'h0, ba[6:3]});
        end
    endfunction

    // addressing mode from the opcode alone
    function automatic oag_mode_t op_mode(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;

        // opcode nibbles
        hi = op[7:4];
        lo = op[3:0];
        if (op == OP_CTM_PC || op == OP_CTM_DP) begin
            // code table reads
            op_mode = MODE_IDX;
        end else if (op == OP_BR_CARRY || op == OP_BR_NCARRY || op == OP_BR_ZERO
                     || op == OP_BR_NZERO || op == OP_BR_ALWAYS) begin
            // short branches
            op_mode = MODE_REL;
        end else if (op[REG_BIT]) begin
            // r0 to r7
            op_mode = MODE_REG;
        end else if (op[3:1] == IND_PATTERN) begin
            // @r0 or @r1
            op_mode = MODE_IND;
        end else if (lo == LO_DIRECT) begin
            // address byte
            op_mode = MODE_DIR;
        end else if (lo == LO_IMM_ACC && hi >= HI_IMM_FIRST && hi <= HI_IMM_LAST) begin
            // value byte
            op_mode = MODE_IMM;
        end else if (lo == LO_BIT && hi >= HI_BIT_FIRST && hi <= HI_BIT_LAST) begin
            // bit address byte
            op_mode = MODE_BIT;
        end else begin
            // opcode-only forms
            op_mode = MODE_IMP;
        end
    endfunction

    // implicit register named by the opcode
    function automatic oag_imp_t op_imp(input logic [7:0] op);
        if (op == OP_MUL_AB || op == OP_DIV_AB) begin
            // multiply, divide
            op_imp = IMP_B;
        end else if (op == OP_INC_DP) begin
            // pointer increment
            op_imp = IMP_DATA_POINTER;
        end else if (op[3:0] == LO_CARRY && op[7:4] >= HI_CARRY_FIRST
                     && op[7:4] <= HI_CARRY_LAST) begin
            // carry-only forms
            op_imp = IMP_CARRY;
        end else begin
            // accumulator
            op_imp = IMP_ACC;
        end
    endfunction

    // ****************************************************************
    // state and working register addresses
    // ****************************************************************
    // state and its next value
    oag_regs_t   s_reg;
    oag_regs_t   s_next;

    // working register address path
    logic [7:0]  reg_ram_addr;
    logic [2:0]  reg_idx;

    // decode and branch terms
    oag_mode_t   dec_mode;
    logic [15:0] rel_offset;
    logic [15:0] rel_target;
    logic [15:0] idx_base;
    logic        br_take;

    // register mode uses op[2:0]; indirect reads r0 or r1 by op[0]
    assign reg_idx = i_instr.op[REG_BIT] ? i_instr.op[2:0] : {2'b00, i_instr.op[0]};

    // bank bits pick the register window
    oag_bank_map u_bank_map (
        .i_bank_hi  (i_core.bank_select_high),
        .i_bank_lo  (i_core.bank_select_low),
        .i_reg_idx  (reg_idx),
        .o_ram_addr (reg_ram_addr)
    );

    // mode of the current opcode
    assign dec_mode   = op_mode(i_instr.op);

    // offset byte read as a signed value
    assign rel_offset = {{8{i_instr.b1[7]}}, i_instr.b1};

    // target counts from the following instruction
    assign rel_target = 16'(i_core.pc_next + rel_offset);

    // index base: data pointer or program counter
    assign idx_base   = (i_instr.op == OP_CTM_DP) ? i_core.data_pointer : i_core.pc_next;

    // branch condition by opcode
    always_comb begin
        case (i_instr.op)
            // carry set
            OP_BR_CARRY:  br_take = i_core.carry;
            // carry clear
            OP_BR_NCARRY: br_take = ~i_core.carry;
            // accumulator zero
            OP_BR_ZERO:   br_take = (i_core.acc == 8'h00);
            // accumulator not zero
            OP_BR_NZERO:  br_take = (i_core.acc != 8'h00);
            // short jump always taken
            default:      br_take = 1'b1;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        // hold state by default; done is a pulse
        s_next      = s_reg;
        s_next.done = 1'b0;

        case (s_reg.st)
            // take a request
            ST_IDLE: begin
                if (i_valid) begin
                    // a new result replaces the old one
                    s_next.res      = '0;
                    s_next.res.mode = dec_mode;
                    s_next.res.imp  = IMP_NONE;
                    s_next.done     = 1'b1;

                    case (dec_mode)
                        // value from the operand byte
                        MODE_IMM: begin
                            s_next.res.space = SP_IMM;
                            s_next.res.value = i_instr.b1;
                            s_next.res.imp   = IMP_ACC;
                        end

                        // operand byte is the address
                        MODE_DIR: begin
                            s_next.res.space = direct_space(i_instr.b1);
                            s_next.res.addr  = {8'h00, i_instr.b1};
                            s_next.res.imp   = IMP_ACC;
                        end

                        MODE_IND: begin
                            // first fetch the pointer held in r0 or r1
                            s_next.done      = 1'b0;
                            s_next.mem.rd    = 1'b1;
                            s_next.mem.space = SP_IRAM;
                            s_next.mem.addr  = {8'h00, reg_ram_addr};
                            s_next.st        = ST_PTR;
                        end

                        // register in the selected bank
                        MODE_REG: begin
                            s_next.res.space = SP_IRAM;
                            s_next.res.addr  = {8'h00, reg_ram_addr};
                            s_next.res.imp   = IMP_ACC;
                        end

                        // branch target or next address
                        MODE_REL: begin
                            s_next.res.space     = SP_CODE;
                            s_next.res.pc_target = br_take ? rel_target : i_core.pc_next;
                            s_next.res.pc_load   = br_take;
                        end

                        MODE_IDX: begin
                            // table byte read from code space at base plus acc
                            s_next.done      = 1'b0;
                            s_next.mem.rd    = 1'b1;
                            s_next.mem.space = SP_CODE;
                            s_next.mem.addr  = 16'(idx_base + {8'h00, i_core.acc});
                            s_next.st        = ST_CODE;
                        end

                        // byte holding the bit
                        MODE_BIT: begin
                            s_next.res.space   = SP_BIT;
                            s_next.res.addr    = {8'h00, bit_byte(i_instr.b1)};
                            s_next.res.bit_idx = i_instr.b1[2:0];
                            s_next.res.imp     = IMP_CARRY;
                        end

                        // opcode-only register
                        default: begin
                            s_next.res.space = SP_CORE;
                            s_next.res.imp   = op_imp(i_instr.op);
                        end
                    endcase
                end
            end

            // pointer read; requests are dropped meanwhile
            ST_PTR: begin
                if (i_mem_ack) begin
                    // pointer contents always address internal ram, never sfr
                    s_next.mem       = '0;
                    s_next.res.space = SP_IRAM;
                    s_next.res.addr  = {8'h00, i_mem_rdata};
                    s_next.res.imp   = IMP_ACC;
                    s_next.done      = 1'b1;
                    s_next.st        = ST_IDLE;
                end
            end

            // table read; byte goes to the accumulator
            ST_CODE: begin
                if (i_mem_ack) begin
                    s_next.mem          = '0;
                    s_next.res.space    = SP_CODE;
                    s_next.res.addr     = s_reg.mem.addr;
                    s_next.res.imp      = IMP_ACC;
                    s_next.res.acc_load = 1'b1;
                    s_next.res.acc_data = i_mem_rdata;
                    s_next.done         = 1'b1;
                    s_next.st           = ST_IDLE;
                end
            end

            // illegal state code: back to idle
            default: begin
                s_next    = '0;
                s_next.st = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // cleared to idle on reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_reg    <= '0;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // ready only while no read is pending
    assign o_ready = (s_reg.st == ST_IDLE);

    // registered request and result
    assign o_mem   = s_reg.mem;
    assign o_done  = s_reg.done;
    assign o_res   = s_reg.res;

endmodule

// ==== testbench/oag_props.sv ====
// assertion checker for the operand address generator ports
// assumes one core clock and an active low asynchronous reset
`timescale 1ns/1ps

module oag_props
    import oag_pkg::*;
(
    // clock and reset
    input wire logic         i_clk,
    input wire logic         i_nrst,
    // request and memory port
    input wire logic         i_valid,
    input wire oag_instr_t   i_instr,
    input wire oag_core_t    i_core,
    input wire logic         o_ready,
    input wire oag_mem_req_t o_mem,
    input wire logic         i_mem_ack,
    input wire logic [7:0]   i_mem_rdata,
    // result
    input wire logic         o_done,
    input wire oag_res_t     o_res
);
    // ************************************************************
    // helper terms and properties
    // ************************************************************
    logic        take;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [1:0]  bank;
    logic [15:0] rel_tgt;
    logic [15:0] idx_dp;
    logic [7:0]  bit_byte;

    // request fields and expected addresses
    assign take = i_valid && o_ready;
    assign op = i_instr.op;
    assign b1 = i_instr.b1;
    assign bank = {i_core.bank_select_high, i_core.bank_select_low};
    assign rel_tgt = i_core.pc_next + {{8{b1[7]}}, b1};
    assign idx_dp = i_core.data_pointer + {8'h00, i_core.acc};
    assign bit_byte = b1[7] ? (b1 & SFR_ROW_MASK) : (BIT_RAM_BASE + {4'h0, b1[6:3]});

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    chk_imm_value: assert property (
        take && op[3:0] == LO_IMM_ACC && op[7:4] >= HI_IMM_FIRST && op[7:4] <= HI_IMM_LAST
        |=> o_done && o_res.mode == MODE_IMM && o_res.value == $past(b1))
        else $error("immediate operand not taken from instruction");
    chk_direct_addr: assert property (
        take && op[3:0] == LO_DIRECT |=> o_done && o_res.mode == MODE_DIR
        && o_res.addr == {8'h00, $past(b1)} && o_res.space == ($past(b1[7]) ? SP_SFR : SP_IRAM))
        else $error("direct address or space wrong");
    chk_reg_bank: assert property (
        take && op[3] |=> o_done && o_res.mode == MODE_REG
        && o_res.addr == {11'h000, $past(bank), $past(op[2:0])})
        else $error("register address wrong");
    chk_ind_read: assert property (
        take && op[3:1] == IND_PATTERN |=> !o_done && !o_ready && o_mem.rd
        && o_mem.space == SP_IRAM && o_mem.addr == {11'h000, $past(bank), 2'b00, $past(op[0])})
        else $error("indirect pointer read wrong");
    chk_ind_space: assert property (
        o_done && o_res.mode == MODE_IND |-> o_res.space == SP_IRAM && o_res.addr[15:8] == 8'h00)
        else $error("indirect access left internal ram");
    chk_rel_carry: assert property (
        take && op == OP_BR_CARRY |=> o_done && o_res.pc_load == $past(i_core.carry)
        && o_res.pc_target == ($past(i_core.carry) ? $past(rel_tgt) : $past(i_core.pc_next)))
        else $error("carry branch target wrong");
    chk_bit_addr: assert property (
        take && op[3:0] == LO_BIT && op[7:4] >= HI_BIT_FIRST && op[7:4] <= HI_BIT_LAST
        |=> o_done && o_res.mode == MODE_BIT && o_res.imp == IMP_CARRY
        && o_res.bit_idx == $past(b1[2:0]) && o_res.addr == {8'h00, $past(bit_byte)})
        else $error("bit address wrong");
    chk_idx_base: assert property (
        take && op == OP_CTM_DP |=> o_mem.rd && o_mem.space == SP_CODE
        && o_mem.addr == $past(idx_dp))
        else $error("indexed code address wrong");
    chk_ctm_load: assert property (
        o_mem.rd && o_mem.space == SP_CODE && i_mem_ack
        |=> o_done && o_res.acc_load && o_res.acc_data == $past(i_mem_rdata))
        else $error("code byte not loaded");
    chk_imp_data_pointer: assert property (
        take && op == OP_INC_DP |=> o_done && o_res.imp == IMP_DATA_POINTER)
        else $error("implicit pointer not selected");
    chk_rd_hold: assert property (
        o_mem.rd && !i_mem_ack |=> o_mem.rd && $stable(o_mem.addr))
        else $error("read dropped before answer");

    // main scenarios
    cover property (o_done && o_res.mode == MODE_IND);
    cover property (o_done && o_res.mode == MODE_REL && o_res.pc_load);
    cover property (o_done && o_res.acc_load);
endmodule

bind oag_operand_addr_gen oag_props u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_instr(i_instr),
    .i_core(i_core), .o_ready(o_ready), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_done(o_done), .o_res(o_res));

// ==== testbench/oag_mem_model.sv ====
// memory partner: internal ram and code memory answering read requests
// assumes requests are held until the ack edge; answers after i_lat cycles
`timescale 1ns/1ps

module oag_mem_model
    import oag_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // read request and answer
    input  wire oag_mem_req_t i_mem,
    input  wire logic [3:0]   i_lat,
    output logic              o_ack,
    output logic [7:0]        o_rdata
);
    // ************************************************************
    // answer process
    // ************************************************************
    int cnt;

    // contents are a fixed function of the address
    initial begin
        o_ack = 1'b0;
        o_rdata = 8'ha5;
        cnt = 0;
        forever begin
            @(posedge i_clk);
            #1;
            if (o_ack || !i_nrst) begin
                o_ack = 1'b0;
                o_rdata = ~o_rdata;
                cnt = 0;
            end else if (i_mem.rd && cnt >= i_lat) begin
                o_ack = 1'b1;
                o_rdata = (i_mem.space == SP_CODE) ? i_mem.addr[7:0] + i_mem.addr[15:8]
                                                    : i_mem.addr[7:0] ^ 8'h5a;
            end else begin
                if (i_mem.rd) cnt++;
                o_rdata = ~o_rdata; // stale data never looks valid
            end
        end
    end
endmodule

// ==== testbench/operand_address_generator_tb.sv ====
// self-checking bench for the operand address generator
// assumes the memory partner answers reads; checker bound from its own file
`timescale 1ns/1ps

module operand_address_generator_tb;
    import oag_pkg::*;

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

    // ************************************************************
    // signals, clock, partner
    // ************************************************************
    logic         i_clk = 1'b0;
    logic         i_nrst = 1'b0;
    logic         i_valid = 1'b0;
    oag_instr_t   i_instr = '0;
    oag_core_t    i_core = '0;
    logic         o_ready;
    oag_mem_req_t o_mem;
    logic         i_mem_ack;
    logic [7:0]   i_mem_rdata;
    logic         o_done;
    oag_res_t     o_res;
    logic [3:0]   lat = 4'h0;
    int           errors = 0;
    int           comparisons = 0;

    initial forever #5 i_clk = ~i_clk;

    oag_operand_addr_gen uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
        .i_instr(i_instr), .i_core(i_core), .o_ready(o_ready), .o_mem(o_mem),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_done(o_done), .o_res(o_res));
    oag_mem_model u_mem (.i_clk(i_clk), .i_nrst(i_nrst), .i_mem(o_mem), .i_lat(lat),
        .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one request, then wait for the result pulse
    task automatic req(input logic [7:0] op, input logic [7:0] b1);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        i_valid = 1'b1;
        i_instr = '{op: op, b1: b1};
        @(posedge i_clk);
        #1;
        i_valid = 1'b0;
        while (o_done !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `CHK("done", 1'b1, o_done)
    endtask

    task automatic t_imm_dir;
        req(8'h74, 8'h50);
        `CHK("imm value", 8'h50, o_res.value)
        req(8'he5, 8'h50);
        `CHK("dir addr", 16'h0050, o_res.addr)
        `CHK("dir space", SP_IRAM, o_res.space)
        req(8'he5, 8'h90);
        `CHK("sfr space", SP_SFR, o_res.space)
    endtask

    task automatic t_reg;
        for (int bk = 0; bk < 4; bk++) begin
            for (int r = 0; r < 8; r += 7) begin
                {i_core.bank_select_high, i_core.bank_select_low} = bk[1:0];
                req(8'h08 | r[7:0], 8'h00);
                `CHK("reg mode", MODE_REG, o_res.mode)
                `CHK("reg addr", 16'(bk * 8 + r), o_res.addr)
            end
        end
    endtask

    task automatic t_ind;
        {i_core.bank_select_high, i_core.bank_select_low} = 2'b01;
        req(8'he7, 8'h00);
        `CHK("ind addr", 16'h0053, o_res.addr)
        `CHK("ind space", SP_IRAM, o_res.space)
        lat = 4'h3;
        {i_core.bank_select_high, i_core.bank_select_low} = 2'b10;
        req(8'he6, 8'h00);
        `CHK("ind slow addr", 16'h004a, o_res.addr)
        lat = 4'h0;
    endtask

    task automatic t_rel;
        logic [16:0] tb [3] = '{{1'b0, 16'h0100}, {1'b1, 16'h017f}, {1'b1, 16'h0080}};
        logic [7:0]  ofs [3] = '{8'h50, 8'h7f, 8'h80};
        i_core.pc_next = 16'h0100;
        for (int k = 0; k < 3; k++) begin
            i_core.carry = tb[k][16];
            req(OP_BR_CARRY, ofs[k]);
            `CHK("rel load", tb[k][16], o_res.pc_load)
            `CHK("rel target", tb[k][15:0], o_res.pc_target)
        end
    endtask

    task automatic t_ctm;
        lat = 4'h2;
        i_core.data_pointer = 16'h1000;
        i_core.acc = 8'h05;
        req(OP_CTM_DP, 8'h00);
        `CHK("ctm addr", 16'h1005, o_res.addr)
        `CHK("ctm data", 8'h15, o_res.acc_data)
        i_core.pc_next = 16'h0200;
        req(OP_CTM_PC, 8'h00);
        `CHK("ctm pc addr", 16'h0205, o_res.addr)
        `CHK("ctm pc data", 8'h07, o_res.acc_data)
        lat = 4'h0;
    endtask

    task automatic t_bit_imp;
        logic [7:0] ops [5] = '{8'h84, 8'ha4, 8'ha3, 8'hb3, 8'he4};
        oag_imp_t   exp [5] = '{IMP_B, IMP_B, IMP_DATA_POINTER, IMP_CARRY, IMP_ACC};
        req(8'ha2, 8'h20);
        `CHK("bit addr low", 16'h0024, o_res.addr)
        `CHK("bit idx low", 3'h0, o_res.bit_idx)
        req(8'ha2, 8'hd7);
        `CHK("bit addr sfr", 16'h00d0, o_res.addr)
        `CHK("bit idx sfr", 3'h7, o_res.bit_idx)
        `CHK("bit carry", IMP_CARRY, o_res.imp)
        for (int k = 0; k < 5; k++) begin
            req(ops[k], 8'h00);
            `CHK("implicit", exp[k], o_res.imp)
        end
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        t_imm_dir();
        t_reg();
        t_ind();
        t_rel();
        t_ctm();
        t_bit_imp();
        end_of_test();
    end

    initial begin
        #20000;
        errors++;
        end_of_test();
    end
endmodule
